// *** shared/asfb_pkg.sv ***
package asfb_pkg;

   // default widths and options of the bridge
   localparam int ADDR_BUS_WIDTH_DEF      = 32;
   localparam int REQ_ID_WIDTH_DEF        = 1;
   localparam int DATA_BUS_WIDTH_DEF      = 32;
   localparam int DATA_BUS_WIDTH_WIDE     = 64;
   localparam int BURST_SUPPORT_DEF       = 0;
   localparam int POSTED_WRITE_OPTION_DEF = 0;

   // ahb field encodings and positions
   localparam logic [1:0] HTRANS_IDLE    = 2'h0;
   localparam logic [1:0] HTRANS_BUSY    = 2'h1;
   localparam logic [1:0] HTRANS_NONSEQ  = 2'h2;
   localparam logic [1:0] HTRANS_SEQ     = 2'h3;
   localparam int         HTRANS_ACT_BIT = 1;
   localparam logic [2:0] HBURST_SINGLE  = 3'h0;
   localparam int         HPROT_BUF_BIT  = 2;
   localparam logic       HRESP_OKAY     = 1'h0;
   localparam logic       HRESP_ERROR    = 1'h1;

   // reset values of the slow-side response
   localparam logic       HREADYOUT_RST  = 1'h1;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_DATA = 3'h2,
      ST_RESP = 3'h4
   } asfb_state_t;

   // a write may be posted only when the option is built in
   function automatic logic asfb_is_posted(input logic       opt,
                                           input logic       wr,
                                           input logic [3:0] prot);
      return opt & wr & prot[HPROT_BUF_BIT];
   endfunction

   // without burst support every active beat leaves as a single transfer
   function automatic logic [1:0] asfb_map_trans(input logic       bursts,
                                                 input logic [1:0] tr);
      if (!bursts && tr[HTRANS_ACT_BIT]) begin
         return HTRANS_NONSEQ;
      end
      return tr;
   endfunction

endpackage

// *** rtl/asfb_hold_slot.sv ***
`timescale 1ns/100ps
module asfb_hold_slot
   import asfb_pkg::*;
#(
   parameter int aw = ADDR_BUS_WIDTH_DEF,
   parameter int mw = REQ_ID_WIDTH_DEF
) (
   input  wire  logic          clock_in,     // fast clock
   input  wire  logic          rstn_in,      // async reset, active low
   input  wire  logic          load_in,      // capture a transfer
   input  wire  logic          clear_in,     // held transfer issued
   input  wire  logic [aw-1:0] haddr_in,     // address to hold
   input  wire  logic [1:0]    htrans_in,    // transfer type to hold
   input  wire  logic [2:0]    hsize_in,     // size to hold
   input  wire  logic          hwrite_in,    // direction to hold
   input  wire  logic [3:0]    hprot_in,     // protection to hold
   input  wire  logic [mw-1:0] hmaster_in,   // requester id to hold
   input  wire  logic          hmastlock_in, // lock to hold
   input  wire  logic [2:0]    hburst_in,    // burst type to hold
   output logic                valid_out,    // a transfer is held
   output logic [aw-1:0]       haddr_out,    // held address
   output logic [1:0]          htrans_out,   // held transfer type
   output logic [2:0]          hsize_out,    // held size
   output logic                hwrite_out,   // held direction
   output logic [3:0]          hprot_out,    // held protection
   output logic [mw-1:0]       hmaster_out,  // held requester id
   output logic                hmastlock_out,// held lock
   output logic [2:0]          hburst_out    // held burst type
);

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         valid_out <= 1'h0;
      end else if (load_in) begin
         valid_out <= 1'h1;
      end else if (clear_in) begin
         valid_out <= 1'h0;
      end
   end

   // fields need no reset: they are only read while valid_out is high
   always_ff @(posedge clock_in) begin
      if (load_in) begin
         haddr_out     <= haddr_in;
         htrans_out    <= htrans_in;
         hsize_out     <= hsize_in;
         hwrite_out    <= hwrite_in;
         hprot_out     <= hprot_in;
         hmaster_out   <= hmaster_in;
         hmastlock_out <= hmastlock_in;
         hburst_out    <= hburst_in;
      end
   end

endmodule

// *** rtl/asfb_bridge.sv ***
`timescale 1ns/100ps
// What this block does
// - with bursts off, each burst beat leaves as a single transfer
// - with bursts on, bursts are forwarded as bursts
// - address width of both ports is a parameter, default 32
// - requester id width is a parameter, default 1
// - data width is 32 or 64 only, default 32
// - posted write option 1 builds a one-level buffer, 0 none
// - with the buffer, the bufferable protection bit picks buffering
// - a failed posted write gives a one-cycle error pulse
// - fast-side address and control follow slow inputs combinationally
// - responses to the slow side are registered, adding a cycle
// - slow clock enable marks slow edges and sets the ratio
// - a posted write issued live to a ready downstream gets OKAY at once, written downstream later
// - only bufferable writes are posted; reads always wait
// - a transfer during a posted write is held with wait states
module asfb_bridge
   import asfb_pkg::*;
#(
   parameter int addr_bus_width      = ADDR_BUS_WIDTH_DEF,
   parameter int requester_id_width  = REQ_ID_WIDTH_DEF,
   parameter int data_bus_width      = DATA_BUS_WIDTH_DEF,
   parameter int burst_support       = BURST_SUPPORT_DEF,
   parameter int posted_write_option = POSTED_WRITE_OPTION_DEF
) (
   input  wire  logic                          clock_in,        // fast clock
   input  wire  logic                          rstn_in,         // reset, low
   input  wire  logic                          slow_clock_enable_in, // slow edge
   input  wire  logic                          hsel_s_in,       // slow select
   input  wire  logic [addr_bus_width-1:0]     haddr_s_in,      // slow addr
   input  wire  logic [1:0]                    htrans_s_in,     // slow type
   input  wire  logic [2:0]                    hsize_s_in,      // slow size
   input  wire  logic                          hwrite_s_in,     // slow dir
   input  wire  logic [3:0]                    hprot_s_in,      // slow prot
   input  wire  logic [requester_id_width-1:0] hmaster_s_in,    // slow id
   input  wire  logic                          hmastlock_s_in,  // slow lock
   input  wire  logic [2:0]                    hburst_s_in,     // slow burst
   input  wire  logic [data_bus_width-1:0]     hwdata_s_in,     // slow wdata
   input  wire  logic                          hready_s_in,     // slow ready
   output logic                                hreadyout_s_out, // to slow
   output logic                                hresp_s_out,     // to slow
   output logic [data_bus_width-1:0]           hrdata_s_out,    // to slow
   output logic [addr_bus_width-1:0]           haddr_m_out,     // fast addr
   output logic [1:0]                          htrans_m_out,    // fast type
   output logic [2:0]                          hsize_m_out,     // fast size
   output logic                                hwrite_m_out,    // fast dir
   output logic [3:0]                          hprot_m_out,     // fast prot
   output logic [requester_id_width-1:0]       hmaster_m_out,   // fast id
   output logic                                hmastlock_m_out, // fast lock
   output logic [2:0]                          hburst_m_out,    // fast burst
   output logic [data_bus_width-1:0]           hwdata_m_out,    // fast wdata
   input  wire  logic                          hready_m_in,     // fast ready
   input  wire  logic                          hresp_m_in,      // fast resp
   input  wire  logic [data_bus_width-1:0]     hrdata_m_in,     // fast rdata
   output logic                                buffered_write_error_pulse_out
);

   localparam logic BURSTS = (burst_support != 0);
   localparam logic POSTOK = (posted_write_option != 0);

   asfb_state_t                         state_r;
   logic                                posted_r;
   logic                                rel_r;
   logic                                post_wait_r;
   logic                                wcap_r;
   logic                                err_r;
   logic                                err_phase_r;
   logic                                burst_on_r;
   logic                                buffered_write_error_pulse_r;
   logic                                hreadyout_r;
   logic                                hresp_r;
   logic [data_bus_width-1:0]           hrdata_r;
   logic [data_bus_width-1:0]           rdata_buf_r;
   logic [data_bus_width-1:0]           wbuf_r;
   logic                                hold_valid;
   logic [addr_bus_width-1:0]           hold_haddr;
   logic [1:0]                          hold_htrans;
   logic [2:0]                          hold_hsize;
   logic                                hold_hwrite;
   logic [3:0]                          hold_hprot;
   logic [requester_id_width-1:0]       hold_hmaster;
   logic                                hold_hmastlock;
   logic [2:0]                          hold_hburst;
   logic                                take_s;
   logic                                free;
   logic                                issue_live;
   logic                                issue_hold;
   logic                                issuing;
   logic                                accept;
   logic                                hold_load;
   logic                                posted_live;
   logic                                posted_hold;
   logic                                posted_now;
   logic                                done;
   logic                                resp_step;
   logic [1:0]                          src_htrans;
   logic [2:0]                          src_hburst;

   assign take_s = slow_clock_enable_in & hsel_s_in & hready_s_in &
                   htrans_s_in[HTRANS_ACT_BIT];
   assign free        = (state_r == ST_IDLE) & ~hold_valid;
   assign issue_live  = take_s & free;
   assign issue_hold  = hold_valid & (state_r == ST_IDLE);
   assign issuing     = issue_live | issue_hold;
   assign accept      = issuing & hready_m_in;
   // hold while the downstream is busy
   assign hold_load   = (take_s & ~free) | (issue_live & ~hready_m_in);
   assign posted_live = asfb_is_posted(POSTOK, hwrite_s_in, hprot_s_in);
   assign posted_hold = asfb_is_posted(POSTOK, hold_hwrite, hold_hprot);
   assign posted_now  = issue_hold ? posted_hold : posted_live;
   assign done        = (state_r == ST_DATA) & hready_m_in;
   assign resp_step   = slow_clock_enable_in & (state_r == ST_RESP);

   asfb_hold_slot #(
      .aw (addr_bus_width),
      .mw (requester_id_width)
   ) u_hold (
      .clock_in      (clock_in),
      .rstn_in       (rstn_in),
      .load_in       (hold_load),
      .clear_in      (accept & issue_hold),
      .haddr_in      (haddr_s_in),
      .htrans_in     (htrans_s_in),
      .hsize_in      (hsize_s_in),
      .hwrite_in     (hwrite_s_in),
      .hprot_in      (hprot_s_in),
      .hmaster_in    (hmaster_s_in),
      .hmastlock_in  (hmastlock_s_in),
      .hburst_in     (hburst_s_in),
      .valid_out     (hold_valid),
      .haddr_out     (hold_haddr),
      .htrans_out    (hold_htrans),
      .hsize_out     (hold_hsize),
      .hwrite_out    (hold_hwrite),
      .hprot_out     (hold_hprot),
      .hmaster_out   (hold_hmaster),
      .hmastlock_out (hold_hmastlock),
      .hburst_out    (hold_hburst)
   );

   // the forward path must be combinational, so these fast-side outputs
   // are deliberately not flops; only a held transfer comes from storage
   assign src_htrans = issue_hold ? hold_htrans : htrans_s_in;
   assign src_hburst = issue_hold ? hold_hburst : hburst_s_in;
   assign haddr_m_out     = issue_hold ? hold_haddr : haddr_s_in;
   assign hsize_m_out     = issue_hold ? hold_hsize : hsize_s_in;
   assign hwrite_m_out    = issue_hold ? hold_hwrite : hwrite_s_in;
   assign hprot_m_out     = issue_hold ? hold_hprot : hprot_s_in;
   assign hmaster_m_out   = issue_hold ? hold_hmaster : hmaster_s_in;
   assign hmastlock_m_out = issue_hold ? hold_hmastlock : hmastlock_s_in;
   // write data live unless already buffered
   assign hwdata_m_out    = wcap_r ? wbuf_r : hwdata_s_in;

   // bursts forwarded with busy between slow beats
   always_comb begin
      if (issuing) begin
         htrans_m_out = asfb_map_trans(BURSTS, src_htrans);
      end else if (burst_on_r && hsel_s_in && !htrans_s_in[HTRANS_ACT_BIT-1]
                   ^ htrans_s_in[HTRANS_ACT_BIT-1]
                   && htrans_s_in != HTRANS_IDLE
                   && htrans_s_in != HTRANS_NONSEQ) begin
         htrans_m_out = HTRANS_BUSY;
      end else begin
         htrans_m_out = HTRANS_IDLE;
      end
      hburst_m_out = BURSTS ? src_hburst : HBURST_SINGLE;
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_r <= ST_IDLE;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (accept) begin
                  state_r <= ST_DATA;
               end
            end
            ST_DATA: begin
               if (done) begin
                  state_r <= posted_r ? ST_IDLE : ST_RESP;
               end
            end
            ST_RESP: begin
               if (resp_step && (!err_r || err_phase_r)) begin
                  state_r <= ST_IDLE;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         posted_r   <= 1'h0;
         burst_on_r <= 1'h0;
      end else if (accept) begin
         posted_r   <= posted_now;
         burst_on_r <= BURSTS & (src_hburst != HBURST_SINGLE);
      end
   end

   // downstream read data and status wait here for the next slow edge
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rdata_buf_r <= '0;
         err_r       <= 1'h0;
      end else if (done && !posted_r) begin
         rdata_buf_r <= hrdata_m_in;
         err_r       <= hresp_m_in;
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         err_phase_r <= 1'h0;
      end else if (resp_step) begin
         err_phase_r <= err_r & ~err_phase_r;
      end
   end

   // a held posted write still owes the slow master its okay
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rel_r <= 1'h0;
      end else if (accept && issue_hold && posted_hold) begin
         rel_r <= 1'h1;
      end else if (slow_clock_enable_in) begin
         rel_r <= 1'h0;
      end
   end

   // the slow data phase ends one slow edge after okay is shown
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         post_wait_r <= 1'h0;
      end else if (slow_clock_enable_in) begin
         post_wait_r <= rel_r | (issue_live & hready_m_in & posted_live);
      end
   end

   // write data is kept only if the downstream outlives the slow phase
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wbuf_r <= '0;
         wcap_r <= 1'h0;
      end else if (done) begin
         wcap_r <= 1'h0;
      end else if (slow_clock_enable_in && post_wait_r) begin
         wbuf_r <= hwdata_s_in;
         wcap_r <= (state_r == ST_DATA) & posted_r;
      end
   end

   // slow response; a posted write issued live to a ready downstream is answered okay at once
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         hreadyout_r <= HREADYOUT_RST;
         hresp_r     <= HRESP_OKAY;
         hrdata_r    <= '0;
      end else if (slow_clock_enable_in) begin
         if (state_r == ST_RESP && err_r && !err_phase_r) begin
            hreadyout_r <= 1'h0;
            hresp_r     <= HRESP_ERROR;
         end else if (state_r == ST_RESP) begin
            hreadyout_r <= 1'h1;
            hresp_r     <= err_r;
            hrdata_r    <= rdata_buf_r;
         end else if (rel_r) begin
            hreadyout_r <= 1'h1;
            hresp_r     <= HRESP_OKAY;
         end else if (hold_load) begin
            hreadyout_r <= 1'h0;
            hresp_r     <= HRESP_OKAY;
         end else if (issue_live) begin
            hreadyout_r <= posted_live;
            hresp_r     <= HRESP_OKAY;
         end else if (hreadyout_r) begin
            hresp_r     <= HRESP_OKAY;
         end
      end
   end

   // one-cycle pulse for a failed posted write
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         buffered_write_error_pulse_r <= 1'h0;
      end else begin
         buffered_write_error_pulse_r <= done & posted_r & hresp_m_in;
      end
   end

   assign hreadyout_s_out                = hreadyout_r;
   assign hresp_s_out                    = hresp_r;
   assign hrdata_s_out                   = hrdata_r;
   assign buffered_write_error_pulse_out = buffered_write_error_pulse_r;

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rstn_in);

   sequence s_live_post;
      issue_live && hready_m_in && posted_live;
   endsequence
   sequence s_post_fail;
      done && posted_r && hresp_m_in;
   endsequence

   property p_single_only;
      !BURSTS |-> (htrans_m_out != HTRANS_SEQ
                   && hburst_m_out == HBURST_SINGLE);
   endproperty
   a_single_only: assert property (p_single_only)
      else $error("burst beat left while bursts are off");

   property p_burst_fwd;
      (BURSTS && issue_live) |-> (htrans_m_out == htrans_s_in
                                  && hburst_m_out == hburst_s_in);
   endproperty
   a_burst_fwd: assert property (p_burst_fwd)
      else $error("burst not forwarded as burst");

   property p_addr_comb;
      issue_live |-> (haddr_m_out == haddr_s_in
                      && hmaster_m_out == hmaster_s_in);
   endproperty
   a_addr_comb: assert property (p_addr_comb)
      else $error("fast address does not follow slow address");

   property p_width;
      data_bus_width == DATA_BUS_WIDTH_DEF
         || data_bus_width == DATA_BUS_WIDTH_WIDE;
   endproperty
   a_width: assert property (p_width)
      else $error("data width is neither 32 nor 64");

   property p_resp_latency;
      (done && !posted_r) |=> !hreadyout_s_out;
   endproperty
   a_resp_latency: assert property (p_resp_latency)
      else $error("response reached the slow side unregistered");

   property p_post_okay;
      s_live_post |=> (hreadyout_s_out && hresp_s_out == HRESP_OKAY);
   endproperty
   a_post_okay: assert property (p_post_okay)
      else $error("posted write not answered okay");

   property p_read_waits;
      (issue_live && hready_m_in && !hwrite_s_in) |=> !hreadyout_s_out;
   endproperty
   a_read_waits: assert property (p_read_waits)
      else $error("read answered before downstream completion");

   property p_pulse;
      s_post_fail |=> buffered_write_error_pulse_r ##1 !buffered_write_error_pulse_r;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("error pulse not exactly one cycle");

   property p_hold_wait;
      (take_s && !free) |=> (hold_valid && !hreadyout_s_out);
   endproperty
   a_hold_wait: assert property (p_hold_wait)
      else $error("transfer during posted write not held");

   property p_no_post;
      !POSTOK |-> !buffered_write_error_pulse_r && !(issue_live && posted_live);
   endproperty
   a_no_post: assert property (p_no_post)
      else $error("posting seen without the write buffer");

   property p_slow_still;
      !slow_clock_enable_in |=> ($stable(hreadyout_s_out)
                                 && $stable(hresp_s_out)
                                 && $stable(hrdata_s_out));
   endproperty
   a_slow_still: assert property (p_slow_still)
      else $error("slow response changed between slow edges");

endmodule

// *** testbench/asfb_slave_model.sv ***
`timescale 1ns/100ps
module asfb_slave_model
   import asfb_pkg::*;
(
   input  wire logic        clock_in,   // fast clock
   input  wire logic        rstn_in,    // reset, low
   input  wire logic [1:0]  htrans_in,  // type
   input  wire logic        hwrite_in,  // direction
   input  wire logic [31:0] haddr_in,   // address
   input  wire logic [31:0] hwdata_in,  // write data
   input  wire logic [2:0]  waits_in,   // wait states per beat
   input  wire logic        fail_in,    // answer with error
   output logic             hready_out, // ready
   output logic             hresp_out,  // response
   output logic [31:0]      hrdata_out, // read data
   output logic [31:0]      wdata_out   // last data written
);
   logic        dp_r;
   logic        wr_r;
   logic        tog_r;
   logic [2:0]  cnt_r;
   logic [31:0] a_r;
   // error takes two cycles: low ready first, then high
   assign hready_out = !dp_r || cnt_r == waits_in + {2'h0, fail_in};
   assign hresp_out  = dp_r && fail_in && cnt_r >= waits_in;
   // idle data toggles so a stale capture cannot pass
   assign hrdata_out = (dp_r && hready_out && !wr_r) ? ~a_r : {32{tog_r}};
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         dp_r  <= 1'b0;
         cnt_r <= 3'h0;
         tog_r <= 1'b0;
      end else begin
         tog_r <= !tog_r;
         cnt_r <= hready_out ? 3'h0 : cnt_r + 3'h1;
         if (hready_out) begin
            dp_r <= htrans_in[HTRANS_ACT_BIT];
            a_r  <= haddr_in;
            wr_r <= hwrite_in;
         end
         if (dp_r && hready_out && wr_r) begin
            wdata_out <= hwdata_in;
         end
      end
   end
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/100ps
module tb
   import asfb_pkg::*;
;
   logic        clk, rstn, hwrite, fail, rdy_s, resp_s, pulse, rq;
   logic        hready_m, hresp_m;
   logic [1:0]  dv, htrans, htrans_m;
   logic [2:0]  waits, hburst_m, hburst;
   logic [3:0]  hprot;
   logic [31:0] haddr, hwdata, rdata_s, haddr_m, hwdata_m, hrdata_m, wd;
   logic        hwrite_m;
   int          num_errors = 0;
   int          n_checks = 0;
   always #12.5 clk = ~clk;
   always @(negedge clk) dv <= (dv == 2'h2) ? 2'h0 : dv + 2'h1;
   wire en = (dv == 2'h0);
   asfb_bridge #(.posted_write_option(1)) asfb_bridge_i (
      .clock_in(clk), .rstn_in(rstn), .slow_clock_enable_in(en),
      .hsel_s_in(1'b1), .haddr_s_in(haddr), .htrans_s_in(htrans),
      .hsize_s_in(3'h2), .hwrite_s_in(hwrite), .hprot_s_in(hprot),
      .hmaster_s_in(1'b0), .hmastlock_s_in(1'b0), .hburst_s_in(hburst),
      .hwdata_s_in(hwdata), .hready_s_in(rdy_s), .hreadyout_s_out(rdy_s),
      .hresp_s_out(resp_s), .hrdata_s_out(rdata_s), .haddr_m_out(haddr_m),
      .htrans_m_out(htrans_m), .hsize_m_out(), .hwrite_m_out(hwrite_m),
      .hprot_m_out(), .hmaster_m_out(), .hmastlock_m_out(),
      .hburst_m_out(hburst_m), .hwdata_m_out(hwdata_m),
      .hready_m_in(hready_m), .hresp_m_in(hresp_m), .hrdata_m_in(hrdata_m),
      .buffered_write_error_pulse_out(pulse));
   asfb_slave_model asfb_slave_model_i (
      .clock_in(clk), .rstn_in(rstn), .htrans_in(htrans_m),
      .hwrite_in(hwrite_m), .haddr_in(haddr_m), .hwdata_in(hwdata_m),
      .waits_in(waits), .fail_in(fail), .hready_out(hready_m),
      .hresp_out(hresp_m), .hrdata_out(hrdata_m), .wdata_out(wd));
   task automatic chk1(input string nm, input logic e, input logic s);
      n_checks++;
      if (s !== e) begin
         num_errors++;
         $display("MISMATCH %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic chk32(input string nm, input logic [31:0] e,
                        input logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         num_errors++;
         $display("MISMATCH %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // counts enable edges up to one that sees ready high
   task automatic slow_edge(output int n);
      n = 0;
      do begin
         @(posedge clk);
         n += int'(en);
         if (n > 20) begin
            num_errors++;
            end_sim;
         end
      end while (!(en && rdy_s));
   endtask
   always @(negedge clk) begin
      if (rstn && !en) chk1("rdy_hold", rq, rdy_s);
      rq <= rdy_s;
   end
   task automatic xfer(input logic [31:0] a, input logic w,
                       input logic [3:0] p, input logic [1:0] t,
                       input logic [31:0] d, input logic f,
                       output int n, output logic [31:0] q);
      @(negedge clk);
      haddr = a;
      hwrite = w;
      hprot = p;
      htrans = t;
      hburst = (t == HTRANS_SEQ) ? 3'h1 : HBURST_SINGLE;
      slow_edge(n);
      if (f) begin
         chk32("haddr_m", a, haddr_m);
         chk1("htrans_m", 1'b1, htrans_m === HTRANS_NONSEQ);
         chk1("hburst_m", 1'b1, hburst_m === HBURST_SINGLE);
      end
      @(negedge clk);
      htrans = HTRANS_IDLE;
      hwdata = d;
      slow_edge(n);
      q = rdata_s;
      chk1("hresp_s", HRESP_OKAY, resp_s);
   endtask
   task automatic t_read;
      int n;
      logic [31:0] q;
      xfer(32'h0000_1230, 1'b0, 4'h0, HTRANS_NONSEQ, 32'h0, 1'b1, n, q);
      chk1("read_wait", 1'b1, n > 1);
      chk32("hrdata_s", ~32'h0000_1230, q);
   endtask
   task automatic t_wr;
      int n;
      logic [31:0] q;
      waits = 3'h2;
      xfer(32'h0000_0040, 1'b1, 4'h0, HTRANS_SEQ, 32'hA5A5_0001, 1'b1, n, q);
      chk1("nobuf_wait", 1'b1, n > 1);
      chk32("fast_wdata", 32'hA5A5_0001, wd);
   endtask
   task automatic t_posted;
      int n;
      logic [31:0] q;
      // long enough that the next transfer finds the write still downstream
      waits = 3'h6;
      xfer(32'h0000_0080, 1'b1, 4'h4, HTRANS_NONSEQ, 32'h5A5A_0002, 1'b1, n, q);
      chk1("post_fast", 1'b1, n == 1);
      xfer(32'h0000_0ABC, 1'b0, 4'h4, HTRANS_NONSEQ, 32'h0, 1'b0, n, q);
      chk1("held_wait", 1'b1, n > 1);
      chk32("held_rdata", ~32'h0000_0ABC, q);
      chk32("post_wdata", 32'h5A5A_0002, wd);
   endtask
   task automatic t_berr;
      int n;
      logic [31:0] q;
      waits = 3'h1;
      fail = 1'b1;
      xfer(32'h0000_00C0, 1'b1, 4'h4, HTRANS_NONSEQ, 32'h0F0F_0003, 1'b1, n, q);
      chk1("berr_fast", 1'b1, n == 1);
      for (int k = 0; k < 40 && pulse !== 1'b1; k++) @(negedge clk);
      chk1("pulse_on", 1'b1, pulse);
      @(negedge clk);
      chk1("pulse_off", 1'b0, pulse);
      fail = 1'b0;
   endtask
   initial begin
      {clk, rstn, hwrite, fail, dv, htrans, waits, hprot, hburst} = '0;
      {haddr, hwdata} = '0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      rstn = 1'b1;
      t_read;
      t_wr;
      t_posted;
      t_berr;
      end_sim;
   end
endmodule
